// ==== rtl/cmpaux_regs.svh ====
// constants for the comparator auxiliary control block: offsets, bit positions, reset values
// assumes inclusion by bare name from the top module of this block
`ifndef CMPAUX_REGS_SVH
`define CMPAUX_REGS_SVH

// ==========================================================
// register offsets on the plain register port
`define CMPAUX_OFS_ONE_CTRL 3'h0
`define CMPAUX_OFS_TWO_CTRL 3'h1
`define CMPAUX_OFS_AUX_CTRL 3'h2
`define CMPAUX_OFS_IRQ_STAT 3'h3
`define CMPAUX_OFS_IRQ_MASK 3'h4

// ==========================================================
// primary control register fields
`define CMPAUX_PRI_ON 7
`define CMPAUX_PRI_OUT 6
`define CMPAUX_PRI_OE 5
`define CMPAUX_PRI_POL 4
`define CMPAUX_PRI_SPEED 3
`define CMPAUX_PRI_REFIN 2
`define CMPAUX_PRI_CH_HI 1
`define CMPAUX_PRI_CH_LO 0

// ==========================================================
// auxiliary control register fields
`define CMPAUX_AUX_A_COPY 7
`define CMPAUX_AUX_B_COPY 6
`define CMPAUX_AUX_A_RSEL 5
`define CMPAUX_AUX_B_RSEL 4
`define CMPAUX_AUX_A_HYS 3
`define CMPAUX_AUX_B_HYS 2
`define CMPAUX_AUX_A_SYNC 1
`define CMPAUX_AUX_B_SYNC 0

// ==========================================================
// interrupt status / mask fields
`define CMPAUX_IRQ_A 0
`define CMPAUX_IRQ_B 1

// ==========================================================
// reset values
`define CMPAUX_RST_PRI 7'h00
`define CMPAUX_RST_AUX 6'h00
`define CMPAUX_RST_IRQ 2'h0
`define CMPAUX_RST_BYTE 8'h00

`endif

// ==== rtl/cmpaux_pkg.sv ====
// types shared by the comparator auxiliary control block
// assumes the constants header sits in the include path
package cmpaux_pkg;
    // ==========================================================
    // writable part of a primary control register
    typedef struct packed {
        logic on;          // comparator enable
        logic oe;          // drive output pin
        logic pol;         // invert output
        logic speed;       // normal power when 1
        logic ref_in_sel;  // cmp_ref_input_sel: 1 reference output, 0 pin
        logic [1:0] ch;    // inverting input channel
    } cmpaux_pri_t;

    // ==========================================================
    // writable part of the auxiliary control register
    typedef struct packed {
        logic a_ref_sel;   // cmp_a_ref_source_sel
        logic b_ref_sel;   // cmp_b_ref_source_sel
        logic a_hys;       // cmp_a_hysteresis_en
        logic b_hys;       // cmp_b_hysteresis_en
        logic a_sync;      // cmp_a_sync_en
        logic b_sync;      // cmp_b_sync_en
    } cmpaux_aux_t;

    // ==========================================================
    // controls toward one analog comparator core
    typedef struct packed {
        logic enable;          // core powered
        logic speed;           // speed / power mode
        logic hyst_en;         // hysteresis on
        logic ref_fixed_sel;   // 1 fixed_reference, 0 variable_reference
        logic noninv_ref_sel;  // 1 cmp_reference_output, 0 positive pin
        logic [1:0] ch;        // inverting input channel
    } cmpaux_analog_t;
endpackage : cmpaux_pkg

// ==== rtl/cmpaux_sync.sv ====
// one comparator output re-timing stage
// assumes tick_i is a one-cycle pulse marking the prescaled timer edge
`timescale 1ns/1ns
module cmpaux_sync
    import cmpaux_pkg::*;
(
    input wire logic clk_i,      // system clock
    input wire logic rst_n_i,    // synchronous reset, active low
    input wire logic ce_i,       // clock enable
    input wire logic tick_i,     // prescaled timer rising edge
    input wire logic sync_en_i,  // re-time when high
    input wire logic d_i,        // comparator output after polarity
    output logic q_o             // output toward pin, interrupt and mirror
);
    logic held_ff; // value caught at the last tick

    // ==========================================================
    // capture only on the timer tick, the same edge the counter uses
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            held_ff <= 1'b0;
        end else if (ce_i && tick_i) begin
            held_ff <= d_i;
        end
    end

    // async path must stay combinational so unsynced mode adds no latency
    assign q_o = sync_en_i ? held_ff : d_i;
endmodule : cmpaux_sync

// ==== rtl/cmpaux_top.sv ====
// digital control of the comparator auxiliary features: mirrors, references, hysteresis, sync
// assumes raw comparator levels and the timer clock arrive synchronous to SYS_CLK_I
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "cmpaux_regs.svh"
module cmpaux_top
    import cmpaux_pkg::*;
(
    input wire logic SYS_CLK_I,               // 125 MHz system clock
    input wire logic RESETN_I,                // synchronous reset, active low
    input wire logic CE_I,                    // freezes all state while low
    input wire logic [2:0] ADDR_I,            // register address
    input wire logic [7:0] WDATA_I,           // write data
    input wire logic WR_I,                    // write strobe
    input wire logic RD_I,                    // read strobe
    output logic [7:0] RDATA_O,               // read data, cycle after strobe
    input wire logic CMP_A_RAW_I,             // raw core A decision
    input wire logic CMP_B_RAW_I,             // raw core B decision
    input wire logic TMR_CLK_I,               // timer source clock level
    input wire logic [1:0] TMR_PRESCALE_I,    // timer prescale 1,2,4,8
    output logic TIMER_ONE_TICK_O,            // counter increment pulse
    output logic CMP_A_OUT_O,                 // cmp_a_output
    output logic CMP_B_OUT_O,                 // cmp_b_output
    output logic CMP_A_PIN_OE_O,              // drive pin A
    output logic CMP_B_PIN_OE_O,              // drive pin B
    output cmpaux_analog_t CMP_A_ANALOG_O,    // controls for core A
    output cmpaux_analog_t CMP_B_ANALOG_O,    // controls for core B
    output logic IRQ_O                        // level interrupt
);
    // ==========================================================
    // functions

    // comparator level after enable and polarity; off core shows polarity
    function automatic logic cmp_level(input logic raw, input cmpaux_pri_t c);
        cmp_level = c.on ? (raw ^ c.pol) : c.pol;
    endfunction : cmp_level

    // full primary register image with live output bit
    function automatic logic [7:0] pri_image(input cmpaux_pri_t c, input logic out);
        pri_image = {c.on, out, c.oe, c.pol, c.speed, c.ref_in_sel, c.ch};
    endfunction : pri_image

    // build analog control bundle from two registers
    function automatic cmpaux_analog_t analog_of(input cmpaux_pri_t c, input logic rsel,
                                                 input logic hys);
        analog_of.enable = c.on;
        analog_of.speed = c.speed;
        analog_of.hyst_en = hys;
        analog_of.ref_fixed_sel = rsel;
        analog_of.noninv_ref_sel = c.ref_in_sel;
        analog_of.ch = c.ch;
    endfunction : analog_of

    // ==========================================================
    // declarations
    cmpaux_pri_t one_ctrl_ff;     // comparator_one_control writable bits
    cmpaux_pri_t two_ctrl_ff;     // comparator_two_control writable bits
    cmpaux_aux_t aux_ctrl_ff;     // comparator_aux_control writable bits
    logic [1:0] irq_stat_ff;      // sticky change flags
    logic [1:0] irq_mask_ff;      // flag enables
    logic [7:0] rdata_ff;         // read data register
    logic tmr_clk_d_ff;           // previous timer clock level
    logic [2:0] presc_cnt_ff;     // prescaler count
    logic a_latch_ff;             // mismatch latch A
    logic b_latch_ff;             // mismatch latch B
    logic a_mis_d_ff;             // previous mismatch A
    logic b_mis_d_ff;             // previous mismatch B
    logic tmr_rise;               // timer clock rising edge
    logic [2:0] presc_mask;       // terminal count for prescale
    logic tick;                   // prescaled timer edge
    logic a_level;                // core A after polarity
    logic b_level;                // core B after polarity
    logic a_out;                  // core A after sync stage
    logic b_out;                  // core B after sync stage
    logic wr_one;                 // write hits control one
    logic wr_two;                 // write hits control two
    logic wr_aux;                 // write hits aux control
    logic wr_mask;                // write hits mask
    logic rd_one;                 // read hits control one
    logic rd_two;                 // read hits control two
    logic rd_stat;                // read hits status
    logic a_mis;                  // mismatch A
    logic b_mis;                  // mismatch B
    logic [1:0] irq_set;          // new change events
    logic [7:0] nxt_rdata;        // next read data

    // ==========================================================
    // address decode
    assign wr_one = WR_I && (ADDR_I == `CMPAUX_OFS_ONE_CTRL);
    assign wr_two = WR_I && (ADDR_I == `CMPAUX_OFS_TWO_CTRL);
    assign wr_aux = WR_I && (ADDR_I == `CMPAUX_OFS_AUX_CTRL);
    assign wr_mask = WR_I && (ADDR_I == `CMPAUX_OFS_IRQ_MASK);
    assign rd_one = RD_I && (ADDR_I == `CMPAUX_OFS_ONE_CTRL);
    assign rd_two = RD_I && (ADDR_I == `CMPAUX_OFS_TWO_CTRL);
    assign rd_stat = RD_I && (ADDR_I == `CMPAUX_OFS_IRQ_STAT);

    // ==========================================================
    // control registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            one_ctrl_ff <= `CMPAUX_RST_PRI;
            two_ctrl_ff <= `CMPAUX_RST_PRI;
        end else if (CE_I) begin
            // output bit 6 is live status, never stored
            if (wr_one) begin
                one_ctrl_ff <= {WDATA_I[7], WDATA_I[5:0]};
            end
            if (wr_two) begin
                two_ctrl_ff <= {WDATA_I[7], WDATA_I[5:0]};
            end
        end
    end

    // aux register keeps only its six writable bits
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            aux_ctrl_ff <= `CMPAUX_RST_AUX;
        end else if (CE_I && wr_aux) begin
            aux_ctrl_ff <= WDATA_I[5:0]; // mirror positions dropped
        end
    end

    // ==========================================================
    // timer clock edge and prescaler
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            tmr_clk_d_ff <= 1'b0;
        end else if (CE_I) begin
            tmr_clk_d_ff <= TMR_CLK_I;
        end
    end

    assign tmr_rise = TMR_CLK_I && !tmr_clk_d_ff;

    // mask of low count bits that must be all ones for a tick
    always_comb begin
        case (TMR_PRESCALE_I)
            2'h0: presc_mask = 3'h0; // divide by 1
            2'h1: presc_mask = 3'h1; // divide by 2
            2'h2: presc_mask = 3'h3; // divide by 4
            2'h3: presc_mask = 3'h7; // divide by 8
            default: presc_mask = 3'h0;
        endcase
    end

    // sync latch takes the divided edge, not the raw source edge
    assign tick = tmr_rise && ((presc_cnt_ff & presc_mask) == presc_mask);

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            presc_cnt_ff <= 3'h0;
        end else if (CE_I && tmr_rise) begin
            presc_cnt_ff <= presc_cnt_ff + 3'h1;
        end
    end

    // counter outside increments on this very pulse, so capture and count never race
    assign TIMER_ONE_TICK_O = tick;

    // ==========================================================
    // comparator output path
    assign a_level = cmp_level(CMP_A_RAW_I, one_ctrl_ff);
    assign b_level = cmp_level(CMP_B_RAW_I, two_ctrl_ff);

    cmpaux_sync u_sync_a (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .ce_i(CE_I),
        .tick_i(tick),
        .sync_en_i(aux_ctrl_ff.a_sync),
        .d_i(a_level),
        .q_o(a_out)
    );

    cmpaux_sync u_sync_b (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .ce_i(CE_I),
        .tick_i(tick),
        .sync_en_i(aux_ctrl_ff.b_sync),
        .d_i(b_level),
        .q_o(b_out)
    );

    assign CMP_A_OUT_O = a_out;
    assign CMP_B_OUT_O = b_out;
    assign CMP_A_PIN_OE_O = one_ctrl_ff.on && one_ctrl_ff.oe;
    assign CMP_B_PIN_OE_O = two_ctrl_ff.on && two_ctrl_ff.oe;

    // ==========================================================
    // analog routing controls
    // reference choice and input choice stay separate so either core can use the pin
    assign CMP_A_ANALOG_O = analog_of(one_ctrl_ff, aux_ctrl_ff.a_ref_sel, aux_ctrl_ff.a_hys);
    assign CMP_B_ANALOG_O = analog_of(two_ctrl_ff, aux_ctrl_ff.b_ref_sel, aux_ctrl_ff.b_hys);

    // ==========================================================
    // mismatch latches: any access to a primary register refreshes it
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            a_latch_ff <= 1'b0;
            b_latch_ff <= 1'b0;
        end else if (CE_I) begin
            // aux reads are deliberately absent here
            if (rd_one || wr_one) begin
                a_latch_ff <= a_out;
            end
            if (rd_two || wr_two) begin
                b_latch_ff <= b_out;
            end
        end
    end

    assign a_mis = a_out != a_latch_ff;
    assign b_mis = b_out != b_latch_ff;

    // edge of mismatch, not its level, raises the event
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            a_mis_d_ff <= 1'b0;
            b_mis_d_ff <= 1'b0;
        end else if (CE_I) begin
            a_mis_d_ff <= a_mis;
            b_mis_d_ff <= b_mis;
        end
    end

    assign irq_set = {b_mis && !b_mis_d_ff, a_mis && !a_mis_d_ff};

    // ==========================================================
    // interrupt status and mask; a new event beats the read clear
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            irq_stat_ff <= `CMPAUX_RST_IRQ;
        end else if (CE_I) begin
            irq_stat_ff <= (rd_stat ? 2'h0 : irq_stat_ff) | irq_set;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            irq_mask_ff <= `CMPAUX_RST_IRQ;
        end else if (CE_I && wr_mask) begin
            irq_mask_ff <= WDATA_I[1:0];
        end
    end

    assign IRQ_O = |(irq_stat_ff & irq_mask_ff);

    // ==========================================================
    // read mux; both mirror bits are sampled in one cycle, from the two sync stage outputs a_out and b_out
    always_comb begin
        nxt_rdata = `CMPAUX_RST_BYTE;
        if (RD_I) begin
            case (ADDR_I)
                `CMPAUX_OFS_ONE_CTRL: nxt_rdata = pri_image(one_ctrl_ff, a_out);
                `CMPAUX_OFS_TWO_CTRL: nxt_rdata = pri_image(two_ctrl_ff, b_out);
                `CMPAUX_OFS_AUX_CTRL: nxt_rdata = {a_out, b_out, aux_ctrl_ff};
                `CMPAUX_OFS_IRQ_STAT: nxt_rdata = {6'h00, irq_stat_ff};
                `CMPAUX_OFS_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
                default: nxt_rdata = `CMPAUX_RST_BYTE; // unmapped reads zero
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            rdata_ff <= `CMPAUX_RST_BYTE;
        end else if (CE_I) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA_O = rdata_ff;

    // ==========================================================
    // assertions
    a_mirror_a_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && RD_I && ADDR_I == `CMPAUX_OFS_AUX_CTRL) |=> (RDATA_O[7] == $past(a_out)))
        else $error("mirror bit 7 differs from output A");

    a_mirror_pair: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && RD_I && ADDR_I == `CMPAUX_OFS_AUX_CTRL) |=> (RDATA_O[7:6] == $past({a_out, b_out})))
        else $error("mirror pair not from one sample");

    a_aux_read_keep: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (RD_I && ADDR_I == `CMPAUX_OFS_AUX_CTRL) |=> ($stable(a_latch_ff) && $stable(b_latch_ff)))
        else $error("aux read changed a mismatch latch");

    a_ref_select: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && wr_aux) |=> (CMP_A_ANALOG_O.ref_fixed_sel == $past(WDATA_I[5]) &&
                              CMP_B_ANALOG_O.ref_fixed_sel == $past(WDATA_I[4])))
        else $error("reference select not taken from write");

    a_input_route: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && wr_one) |=> (CMP_A_ANALOG_O.noninv_ref_sel == $past(WDATA_I[2])))
        else $error("input select A not taken from write");

    a_input_route_b: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && wr_two) |=> (CMP_B_ANALOG_O.noninv_ref_sel == $past(WDATA_I[2])))
        else $error("input select B not taken from write");

    a_hyst_enable: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && wr_aux) |=> (CMP_A_ANALOG_O.hyst_en == $past(WDATA_I[3]) &&
                              CMP_B_ANALOG_O.hyst_en == $past(WDATA_I[2])))
        else $error("hysteresis enable not taken from write");

    a_sync_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (aux_ctrl_ff.a_sync && !tick && !wr_aux) |=> $stable(CMP_A_OUT_O))
        else $error("synced output A moved without a tick");

    a_async_pass: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        !aux_ctrl_ff.b_sync |-> (CMP_B_OUT_O == b_level))
        else $error("unsynced output B not passed through");

    a_presc_tick: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        TIMER_ONE_TICK_O |-> (tmr_rise && (presc_cnt_ff & presc_mask) == presc_mask))
        else $error("tick outside prescaled timer edge");

    a_same_edge: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (CE_I && TIMER_ONE_TICK_O && aux_ctrl_ff.a_sync && !wr_aux) |=> (CMP_A_OUT_O == $past(a_level)))
        else $error("output A not caught on counter tick");

    a_reset_clear: assert property (@(posedge SYS_CLK_I)
        !RESETN_I |=> (one_ctrl_ff == 7'h00 && two_ctrl_ff == 7'h00 && aux_ctrl_ff == 6'h00))
        else $error("control registers not cleared by reset");
endmodule : cmpaux_top

// ==== sim/cmpaux_partner.sv ====
// model of the two analog comparator cores and of the free-running timer source clock
// assumes the bench drives analog levels as byte codes, changed just after clock edges
`timescale 1ns/1ns
module cmpaux_partner
    import cmpaux_pkg::*;
#(
    parameter int TMR_HALF = 6  // timer half period in system cycles
)
(
    input wire logic clk_i,              // system clock
    input wire logic rst_n_i,            // synchronous reset, active low
    input wire cmpaux_analog_t a_ctl_i,  // controls of core a
    input wire cmpaux_analog_t b_ctl_i,  // controls of core b
    input wire logic [7:0] pin_a_i,      // positive pin level of core a
    input wire logic [7:0] pin_b_i,      // positive pin level of core b
    input wire logic [7:0] inv_i,        // inverting input level, both cores
    output logic raw_a_o,                // decision of core a
    output logic raw_b_o,                // decision of core b
    output logic tmr_clk_o               // timer source clock
);
    // ==========================================================
    // reference levels, arbitrary codes well apart from each other
    localparam logic [8:0] FIXED_V = 9'h080;
    localparam logic [8:0] VAR_V = 9'h040;
    localparam logic [8:0] HYS_V = 9'h008;
    logic a_last_ff;     // previous decision of core a
    logic b_last_ff;     // previous decision of core b
    logic [7:0] cnt_ff;  // timer half period count

    // decision of one core; hysteresis moves the threshold away from the last state
    function automatic logic decide(input cmpaux_analog_t c, input logic [7:0] pin, input logic [7:0] inv,
                                    input logic last);
        logic [8:0] plus;
        plus = c.noninv_ref_sel ? (c.ref_fixed_sel ? FIXED_V : VAR_V) : {1'b0, pin};
        if (c.hyst_en) begin
            plus = last ? plus + HYS_V : plus - HYS_V;
        end
        return plus > {1'b0, inv};
    endfunction : decide

    // a core that is off gives no stable answer, so it flips every cycle
    always_comb begin
        raw_a_o = a_ctl_i.enable ? decide(a_ctl_i, pin_a_i, inv_i, a_last_ff) : ~a_last_ff;
        raw_b_o = b_ctl_i.enable ? decide(b_ctl_i, pin_b_i, inv_i, b_last_ff) : ~b_last_ff;
    end

    // last decisions and the free-running timer oscillator
    always_ff @(posedge clk_i) begin
        a_last_ff <= rst_n_i && raw_a_o; // known start, else hysteresis stays unknown
        b_last_ff <= rst_n_i && raw_b_o;
        if (!rst_n_i || cnt_ff == 8'(TMR_HALF - 1)) begin
            cnt_ff <= 8'h00;
            tmr_clk_o <= rst_n_i ? ~tmr_clk_o : 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : cmpaux_partner

// ==== sim/cmpaux_tb_top.sv ====
// self-checking bench of the comparator auxiliary control block
// assumes the partner model supplies core decisions and a timer clock of 12 system cycles
`timescale 1ns/1ns
module cmpaux_tb_top
    import cmpaux_pkg::*;
;
    // ==========================================================
    // bench-driven inputs, design outputs, counters
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [1:0] presc = 2'h0;
    logic [7:0] pin_a = 8'h10;
    logic [7:0] pin_b = 8'h10;
    logic [7:0] inv_v = 8'h60;
    logic [7:0] rdata, d;
    logic raw_a, raw_b, tmr_clk, tick, out_a, out_b, irq, oe_a, oe_b;
    logic ce = 1'b1;
    cmpaux_analog_t ana_a, ana_b;
    int mismatches = 0;
    int checks_done = 0;

    initial forever #4 sys_clk = ~sys_clk;

    cmpaux_top uut (.SYS_CLK_I(sys_clk), .RESETN_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd_s), .RDATA_O(rdata), .CMP_A_RAW_I(raw_a), .CMP_B_RAW_I(raw_b),
        .TMR_CLK_I(tmr_clk), .TMR_PRESCALE_I(presc), .TIMER_ONE_TICK_O(tick), .CMP_A_OUT_O(out_a),
        .CMP_B_OUT_O(out_b), .CMP_A_PIN_OE_O(oe_a), .CMP_B_PIN_OE_O(oe_b), .CMP_A_ANALOG_O(ana_a),
        .CMP_B_ANALOG_O(ana_b), .IRQ_O(irq));
    cmpaux_partner #(.TMR_HALF(6)) far_side (.clk_i(sys_clk), .rst_n_i(rst_n), .a_ctl_i(ana_a),
        .b_ctl_i(ana_b), .pin_a_i(pin_a), .pin_b_i(pin_b), .inv_i(inv_v), .raw_a_o(raw_a),
        .raw_b_o(raw_b), .tmr_clk_o(tmr_clk));

    // ==========================================================
    // bus cycles, comparison, waiting
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for a timer tick, returning inside the tick cycle
    task automatic wait_tick(output int n);
        n = 0;
        repeat (400) begin
            @(posedge sys_clk);
            #1 n++;
            if (tick === 1'b1) break;
        end
    endtask : wait_tick

    task automatic hold_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : hold_reset

    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a < 6; a++) begin
            rd_reg(3'(a), d);
            chk(d, 8'h00);
        end
        chk({1'b0, ana_a} | {1'b0, ana_b}, 8'h00);
        chk({6'h00, oe_a, oe_b}, 8'h00);
        $display("reset values done");
    endtask : t_reset

    task automatic t_fields();
        wr_reg(3'h2, 8'hff);
        rd_reg(3'h2, d);
        chk(d, 8'h3f);
        chk({1'b0, ana_a}, 8'h18);
        wr_reg(3'h2, 8'h14);
        #1 chk({1'b0, ana_a}, 8'h00);
        chk({1'b0, ana_b}, 8'h18);
        wr_reg(3'h3, 8'hff);
        wr_reg(3'h5, 8'hff);
        rd_reg(3'h3, d);
        chk(d, 8'h00);
        rd_reg(3'h5, d);
        chk(d, 8'h00);
        // a write while the clock enable is low must leave the register alone
        ce <= 1'b0;
        wr_reg(3'h2, 8'h3f);
        ce <= 1'b1;
        rd_reg(3'h2, d);
        chk(d, 8'h14); // frozen write ignored
        $display("field decode done");
    endtask : t_fields

    // core a on the reference output, core b on its pin
    task automatic t_mirror();
        wr_reg(3'h0, 8'ha4);
        wr_reg(3'h1, 8'h80);
        #1 chk({oe_a, ana_a}, 8'hc4);
        chk({oe_b, ana_b}, 8'h58);
        wr_reg(3'h2, 8'h20);
        rd_reg(3'h2, d);
        chk(d, 8'ha0);
        wr_reg(3'h2, 8'h00);
        rd_reg(3'h2, d);
        chk(d, 8'h00);
        wr_reg(3'h1, 8'h90);
        rd_reg(3'h2, d);
        chk(d, 8'h40);
        rd_reg(3'h1, d);
        chk(d, 8'hd0);
        chk({7'h00, out_b}, 8'h01);
        wr_reg(3'h2, 8'h20);
        rd_reg(3'h2, d);
        chk(d, 8'he0);
        $display("mirror copies done");
    endtask : t_mirror

    // status is edge-set; an aux read must not reload the mismatch latch
    task automatic t_irq();
        wr_reg(3'h4, 8'h03);
        rd_reg(3'h0, d);
        rd_reg(3'h3, d);
        chk({7'h00, irq}, 8'h00);
        inv_v <= 8'h90;
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, irq}, 8'h01);
        rd_reg(3'h3, d);
        chk(d, 8'h01);
        rd_reg(3'h2, d);
        inv_v <= 8'h60;
        repeat (3) @(posedge sys_clk);
        rd_reg(3'h3, d);
        chk(d, 8'h00);
        wr_reg(3'h4, 8'h00);
        inv_v <= 8'h90;
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, irq}, 8'h00);
        rd_reg(3'h3, d);
        chk(d, 8'h01);
        $display("interrupt done");
    endtask : t_irq

    task automatic t_sync();
        int n;
        @(posedge sys_clk);
        inv_v <= 8'h60;
        #1 chk({7'h00, out_a}, 8'h01);
        wr_reg(3'h2, 8'h22);
        wait_tick(n);
        @(posedge sys_clk);
        inv_v <= 8'h90;
        repeat (6) @(posedge sys_clk);
        #1 chk({7'h00, out_a}, 8'h01);
        wait_tick(n);
        @(posedge sys_clk);
        #1 chk({7'h00, out_a}, 8'h00);
        for (int p = 0; p < 4; p++) begin
            presc <= 2'(p);
            wait_tick(n);
            wait_tick(n);
            wait_tick(n);
            chk(8'(n), 8'(12 << p));
        end
        $display("output sync done");
    endtask : t_sync

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // main sequence and watchdog
    initial begin
        hold_reset();
        t_reset();
        t_fields();
        t_mirror();
        t_irq();
        t_sync();
        hold_reset();
        t_reset();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end
endmodule : cmpaux_tb_top
